/* File: design/uic_interface_control.sv */
// interface control register bank with serial mode and indicator control
// Notes on behaviour
// - Reads decode 07h to 09h; writes 07h, sets 08h, clears 09h.
// - Protection on: weak stop pull-up, and data pull-downs on a stray high stop.
// - With protection on, a floating stop is caught with no register access.
// - Protection off removes the stop pull-up and the data pull-downs.
// - The invert bit inverts the fault input to form the complement output.
// - Pass-through clear qualifies the complement with supply valid.
// - Active-low clock power bit only steers clock power in serial modes.
// - That bit counts only in a serial mode with the sleep control at one.
// - Three-wire bit moves full and low speed packets to 3-bit serial.
// - The three-wire bit clears itself when three-wire mode ends.
// - Six-wire bit moves full and low speed packets to 6-bit serial.
// - The six-wire bit clears itself when six-wire mode ends.
`timescale 1ns/1ps
module uic_mode_regs
    import uic_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // register access
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [5:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // interface lines
    input wire logic i_stp,
    input wire logic i_stp_expected,
    output logic o_stp_pullup_en,
    output logic [7:0] o_data_pulldown_en,
    // serial mode
    input wire logic i_three_wire_exit,
    input wire logic i_six_wire_exit,
    input wire logic i_phy_sleep_n,
    output logic o_three_wire_serial_mode,
    output logic o_six_wire_serial_mode,
    output logic o_clock_power,
    // supply indicator
    input wire logic i_supply_fault,
    input wire logic i_supply_valid_comparator,
    output logic o_indicator_complement,
    output logic o_supply_state
);
    logic [7:0] interface_control_ff;
    logic [7:0] nxt_interface_control;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic compl_ff;
    logic nxt_compl;
    logic state_ff;
    logic nxt_state;
    logic clk_pwr_ff;
    logic nxt_clk_pwr;
    logic serial_on;
    logic [7:0] wmask;

    uic_guard_if gif ();

    uic_line_guard u_guard (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .g(gif.guard)
    );

    assign gif.guard_disable = interface_control_ff[UIC_BIT_GUARD_DIS];
    assign gif.stp_level = i_stp;
    assign gif.stp_expected = i_stp_expected;
    assign o_stp_pullup_en = gif.stp_pullup_en;
    assign o_data_pulldown_en = gif.data_pulldown_en;

    assign wmask = i_reg_wdata & UIC_WRITE_MASK;
    assign serial_on = interface_control_ff[UIC_BIT_THREE_WIRE]
        || interface_control_ff[UIC_BIT_SIX_WIRE];

    // register update: mode exit first, a link write in the same cycle wins
    always_comb
    begin
        nxt_interface_control = interface_control_ff;
        if (i_three_wire_exit)
        begin
            nxt_interface_control[UIC_BIT_THREE_WIRE] = 1'b0;
        end
        if (i_six_wire_exit)
        begin
            nxt_interface_control[UIC_BIT_SIX_WIRE] = 1'b0;
        end
        if (i_reg_wr && i_reg_addr == UIC_ADDR_WRITE)
        begin
            nxt_interface_control = wmask;
        end
        else if (i_reg_wr && i_reg_addr == UIC_ADDR_SET)
        begin
            nxt_interface_control = interface_control_ff | wmask;
        end
        else if (i_reg_wr && i_reg_addr == UIC_ADDR_CLEAR)
        begin
            nxt_interface_control = interface_control_ff & ~wmask;
        end
    end

    // read data, indicator and clock power
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (i_reg_rd && i_reg_addr >= UIC_ADDR_READ_LO
            && i_reg_addr <= UIC_ADDR_READ_HI)
        begin
            nxt_rdata = interface_control_ff;
        end
        else if (i_reg_rd)
        begin
            nxt_rdata = 8'h00;
        end
        nxt_compl = i_supply_fault
            ^ interface_control_ff[UIC_BIT_IND_INVERT];
        if (interface_control_ff[UIC_BIT_IND_UNQUAL])
        begin
            nxt_state = nxt_compl;
        end
        else
        begin
            nxt_state = nxt_compl && i_supply_valid_comparator;
        end
        if (serial_on && i_phy_sleep_n)
        begin
            nxt_clk_pwr = interface_control_ff[UIC_BIT_CLK_POWER_N];
        end
        else
        begin
            nxt_clk_pwr = i_phy_sleep_n;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            interface_control_ff <= UIC_RESET_VALUE;
            rdata_ff <= 8'h00;
            compl_ff <= 1'b0;
            state_ff <= 1'b0;
            clk_pwr_ff <= 1'b0;
        end
        else
        begin
            interface_control_ff <= nxt_interface_control;
            rdata_ff <= nxt_rdata;
            compl_ff <= nxt_compl;
            state_ff <= nxt_state;
            clk_pwr_ff <= nxt_clk_pwr;
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_three_wire_serial_mode =
        interface_control_ff[UIC_BIT_THREE_WIRE];
    assign o_six_wire_serial_mode =
        interface_control_ff[UIC_BIT_SIX_WIRE];
    assign o_clock_power = clk_pwr_ff;
    assign o_indicator_complement = compl_ff;
    assign o_supply_state = state_ff;

    sequence s_plain_write;
        i_reg_wr && i_reg_addr == UIC_ADDR_WRITE;
    endsequence

    a_plain_write: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        s_plain_write |=> interface_control_ff == $past(wmask))
        else $error("plain write did not replace register");

    a_set_only_ones: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_reg_wr && i_reg_addr == UIC_ADDR_SET && !i_three_wire_exit
        && !i_six_wire_exit) |=> interface_control_ff
        == ($past(interface_control_ff) | $past(wmask)))
        else $error("set access changed wrong bits");

    a_clear_only_ones: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_reg_wr && i_reg_addr == UIC_ADDR_CLEAR) |=> interface_control_ff
        == ($past(interface_control_ff) & ~$past(wmask)))
        else $error("clear access changed wrong bits");

    a_reserved_zero: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_reg_rd |=> o_reg_rdata[4] == 1'b0 && o_reg_rdata[2] == 1'b0)
        else $error("reserved bit read as one");

    a_read_range: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_reg_rd && i_reg_addr == UIC_ADDR_CLEAR)
        |=> o_reg_rdata == $past(interface_control_ff))
        else $error("read at clear address gave wrong data");

    a_three_wire_exit: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_three_wire_exit && !i_reg_wr) |=> !o_three_wire_serial_mode)
        else $error("three-wire bit not cleared on exit");

    a_six_wire_exit: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_six_wire_exit && !i_reg_wr) |=> !o_six_wire_serial_mode)
        else $error("six-wire bit not cleared on exit");

    a_supply_qualify: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (!interface_control_ff[UIC_BIT_IND_UNQUAL]
        && !i_supply_valid_comparator) |=> !o_supply_state)
        else $error("supply state not qualified by comparator");

    a_indicator_invert: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        1'b1 |=> o_indicator_complement == ($past(i_supply_fault)
        ^ $past(interface_control_ff[UIC_BIT_IND_INVERT])))
        else $error("complement output wrong");

    a_clock_power: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (!serial_on && i_phy_sleep_n) |=> o_clock_power)
        else $error("clock power dropped outside serial mode");
endmodule // uic_mode_regs

/* File: design/uic_line_guard.sv */
// weak pull control protecting the stop and data lines
`timescale 1ns/1ps
module uic_line_guard
    import uic_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // register side
    uic_guard_if.guard g
);
    logic stp_pullup_ff;
    logic nxt_stp_pullup;
    logic [7:0] data_pulldown_ff;
    logic [7:0] nxt_data_pulldown;

    always_comb
    begin
        // pull-up held whenever protection is on
        nxt_stp_pullup = !g.guard_disable;
        nxt_data_pulldown = 8'h00;
        // stop line high while the link should not drive it
        if (!g.guard_disable && g.stp_level && !g.stp_expected)
        begin
            nxt_data_pulldown = 8'hFF;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            stp_pullup_ff <= 1'b0;
            data_pulldown_ff <= 8'h00;
        end
        else
        begin
            stp_pullup_ff <= nxt_stp_pullup;
            data_pulldown_ff <= nxt_data_pulldown;
        end
    end

    assign g.stp_pullup_en = stp_pullup_ff;
    assign g.data_pulldown_en = data_pulldown_ff;

    a_pullup_when_on: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        !g.guard_disable |=> g.stp_pullup_en)
        else $error("stop pull-up missing while protection on");

    a_pulls_removed_off: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        g.guard_disable |=> !g.stp_pullup_en && g.data_pulldown_en == 8'h00)
        else $error("weak pulls left on with protection off");

    a_pulldown_on_float: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (!g.guard_disable && g.stp_level && !g.stp_expected)
        |=> g.data_pulldown_en == 8'hFF)
        else $error("data pull-downs not applied on floating stop");

    a_pulldown_idle_off: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (!g.stp_level || g.stp_expected) |=> g.data_pulldown_en == 8'h00)
        else $error("data pull-downs applied without cause");
endmodule // uic_line_guard

/* File: pkg/uic_guard_if.sv */
// carrier between the register bank and the line guard
`timescale 1ns/1ps
interface uic_guard_if;
    logic guard_disable;
    logic stp_level;
    logic stp_expected;
    logic stp_pullup_en;
    logic [7:0] data_pulldown_en;

    modport ctrl (
        output guard_disable,
        output stp_level,
        output stp_expected,
        input stp_pullup_en,
        input data_pulldown_en
    );
    modport guard (
        input guard_disable,
        input stp_level,
        input stp_expected,
        output stp_pullup_en,
        output data_pulldown_en
    );
endinterface

/* File: pkg/uic_pkg.sv */
// constants for the interface control register block
package uic_pkg;
    // register addresses
    localparam logic [5:0] UIC_ADDR_WRITE = 6'h07;
    localparam logic [5:0] UIC_ADDR_SET = 6'h08;
    localparam logic [5:0] UIC_ADDR_CLEAR = 6'h09;
    localparam logic [5:0] UIC_ADDR_READ_LO = 6'h07;
    localparam logic [5:0] UIC_ADDR_READ_HI = 6'h09;
    // field positions
    localparam int UIC_BIT_GUARD_DIS = 7;
    localparam int UIC_BIT_IND_UNQUAL = 6;
    localparam int UIC_BIT_IND_INVERT = 5;
    localparam int UIC_BIT_CLK_POWER_N = 3;
    localparam int UIC_BIT_THREE_WIRE = 1;
    localparam int UIC_BIT_SIX_WIRE = 0;
    // reset value and implemented bits
    localparam logic [7:0] UIC_RESET_VALUE = 8'h00;
    localparam logic [7:0] UIC_WRITE_MASK = 8'hEB;
endpackage

/* File: verif/uic_link_model.sv */
// link controller model for register access and the stop line
`timescale 1ns/1ps
module uic_link_model
(
    // clock
    input wire logic i_core_clk,
    // register access
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [5:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    input wire logic [7:0] i_reg_rdata,
    // stop line
    output logic o_stp,
    output logic o_stp_expected
);
    initial
    begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 6'h00;
        o_reg_wdata = 8'h00;
        o_stp = 1'b0;
        o_stp_expected = 1'b1;
    end

    // one strobe cycle, data taken one edge after
    task automatic access(input logic wr, input logic [5:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge i_core_clk);
        #1;
        o_reg_wr = wr;
        o_reg_rd = !wr;
        o_reg_addr = a;
        o_reg_wdata = d;
        @(posedge i_core_clk);
        #1;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        // released bus shows no stale value
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
        @(posedge i_core_clk);
        #1;
        q = i_reg_rdata;
    endtask

    // stop line driven, floated or raised to wake the device
    task automatic lines(input logic s, input logic e);
        @(posedge i_core_clk);
        #1;
        o_stp = s;
        o_stp_expected = e;
    endtask
endmodule // uic_link_model

/* File: verif/ulpi_interface_control_reg_tb.sv */
// self-checking bench for the interface control register
`timescale 1ns/1ps
module ulpi_interface_control_reg_tb;
    import uic_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr, rd, stp, stp_exp;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, pd, model;
    logic pu, m3, m6, cpw, cmpl, sst;
    logic x3 = 1'b0;
    logic x6 = 1'b0;
    logic sleep_n = 1'b1;
    logic fault = 1'b0;
    logic vld = 1'b0;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] q;
    logic [5:0] ra;

    always #2 clk = ~clk;

    uic_link_model link_u (.i_core_clk(clk), .o_reg_wr(wr), .o_reg_rd(rd),
        .o_reg_addr(addr), .o_reg_wdata(wdata), .i_reg_rdata(rdata),
        .o_stp(stp), .o_stp_expected(stp_exp));

    uic_mode_regs dut_u (.i_core_clk(clk), .i_resetn(rstn), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_stp(stp), .i_stp_expected(stp_exp),
        .o_stp_pullup_en(pu), .o_data_pulldown_en(pd),
        .i_three_wire_exit(x3), .i_six_wire_exit(x6),
        .i_phy_sleep_n(sleep_n), .o_three_wire_serial_mode(m3),
        .o_six_wire_serial_mode(m6), .o_clock_power(cpw),
        .i_supply_fault(fault), .i_supply_valid_comparator(vld),
        .o_indicator_complement(cmpl), .o_supply_state(sst));

    function automatic logic [7:0] next_reg(input logic [5:0] a,
        input logic [7:0] d, input logic [7:0] cur);
        case (a)
            6'h07: return d & UIC_WRITE_MASK;
            6'h08: return cur | (d & UIC_WRITE_MASK);
            6'h09: return cur & ~d;
            default: return cur;
        endcase
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic outs();
        logic c;
        logic p;
        logic w;
        c = fault ^ model[5];
        p = sleep_n & (!(|model[1:0]) | model[3]);
        w = !model[7] && stp && !stp_exp;
        check(8'(cmpl), 8'(c));
        check(8'(sst), 8'(model[6] ? c : c & vld));
        check(8'(pu), 8'(!model[7]));
        check(pd, w ? 8'hFF : 8'h00);
        check(8'(m3), 8'(model[1]));
        check(8'(m6), 8'(model[0]));
        check(8'(cpw), 8'(p));
    endtask

    task automatic wr_chk(input logic [5:0] a, input logic [7:0] d);
        link_u.access(1'b1, a, d, q);
        model = next_reg(a, d, model);
        link_u.access(1'b0, 6'h07 + 6'($urandom_range(2)), 8'h00, q);
        check(q, model);
        outs();
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            $display("wrong value at %0t: run too long", $time);
            end_of_test();
        end
    end

    initial
    begin
        model = UIC_RESET_VALUE;
        void'($urandom(62631));
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        link_u.access(1'b0, 6'h07, 8'h00, q);
        check(q, 8'h00);
        outs();
        link_u.access(1'b0, 6'h0A, 8'h00, q);
        check(q, 8'h00);
        $display("reset and unmapped read done");
        // serial bits kept out of random data, one mode at a time
        for (int i = 0; i < 60; i++)
        begin
            fault = 1'($urandom);
            vld = 1'($urandom);
            sleep_n = 1'($urandom);
            link_u.lines(1'($urandom), 1'($urandom));
            ra = 6'h07 + 6'($urandom_range(3));
            wr_chk(ra, 8'($urandom) & 8'hFC);
        end
        $display("random accesses done");
        sleep_n = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            wr_chk(6'h09, 8'hFF);
            wr_chk(6'h08, 8'(1 << k));
            wr_chk(6'h08, 8'h08);
            sleep_n = 1'b0;
            wr_chk(6'h0A, 8'hFF);
            link_u.lines(1'b1, 1'b1);
            sleep_n = 1'b1;
            @(posedge clk);
            #1;
            x3 = (k == 1);
            x6 = (k == 0);
            @(posedge clk);
            #1;
            x3 = 1'b0;
            x6 = 1'b0;
            model[k] = 1'b0;
            link_u.access(1'b0, 6'h08, 8'h00, q);
            check(q, model);
            outs();
        end
        $display("serial modes done");
        end_of_test();
    end
endmodule // ulpi_interface_control_reg_tb
